// [pwr_key_pkg.sv]
// Shared constants and a ms-to-cycles function for the power key sequencer, both ends.
package pwr_key_pkg;
    // Clock rate of ref_clk
    localparam longint CLK_HZ          = 64'd10000000;
    // Documented times in milliseconds
    localparam longint KEY_MIN_MS      = 64'd1000;
    localparam longint START_HOLD_MS   = 64'd900;
    localparam longint RESET_MIN_MS    = 64'd200;
    // Device-side internal times in milliseconds
    localparam longint BOOT_MS         = 64'd100;
    localparam longint DETACH_MS       = 64'd50;
    localparam longint OFF_MS          = 64'd10;
    // Least times round up to whole cycles
    function automatic longint ms_to_cycles(input longint ms);
        ms_to_cycles = (ms * CLK_HZ + 64'd999) / 64'd1000;
    endfunction : ms_to_cycles
    localparam int KEY_MIN_CYC    = int'(ms_to_cycles(KEY_MIN_MS));
    localparam int START_HOLD_CYC = int'(ms_to_cycles(START_HOLD_MS));
    localparam int RESET_MIN_CYC  = int'(ms_to_cycles(RESET_MIN_MS));
    localparam int BOOT_CYC       = int'(ms_to_cycles(BOOT_MS));
    localparam int DETACH_CYC     = int'(ms_to_cycles(DETACH_MS));
    localparam int OFF_CYC        = int'(ms_to_cycles(OFF_MS));
    localparam int CNT_W          = 24;
endpackage : pwr_key_pkg

// [pwr_key_if.sv]
// Interface joining the module end and the host end over the open-collector lines.
`timescale 1ns/1ps
interface pwr_key_if;
    logic power_key_oe_n;    // Host pull-down enable on power key, low pulls
    logic reset_oe_n;        // Host pull-down enable on reset, low pulls
    logic power_key_n;       // Resolved power key level (internal pull-up)
    logic reset_n;           // Resolved reset level (internal pull-up)
    logic power_state_out;   // Device power status, high when on
    logic start_out;         // Device start indication
    // Pull-ups live in the device; a line only goes low when pulled
    assign power_key_n = power_key_oe_n;
    assign reset_n     = reset_oe_n;
    modport device (input power_key_n, input reset_n, output power_state_out, output start_out);
    modport host   (output power_key_oe_n, output reset_oe_n, input power_state_out, input start_out);
endinterface : pwr_key_if

// [pwr_module_end.sv]
// Module-side power sequencer: power key, unconditional reboot, status outputs.
`timescale 1ns/1ps
module pwr_module_end
    import pwr_key_pkg::*;
#(
    parameter int KEY_CYC    = KEY_MIN_CYC,
    parameter int BOOT_TIME  = BOOT_CYC,
    parameter int DETACH_T   = DETACH_CYC,
    parameter int OFF_T      = OFF_CYC
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Link
    pwr_key_if.device link,
    // User side
    input  wire logic sw_shutdown,     // Software shutdown command pulse
    output logic      detach_req,      // Detach message to network, one pulse
    output logic      powered          // Internal power rail status
);
    typedef enum logic [5:0] {
        S_OFF    = 6'h01,
        S_BOOT   = 6'h02,
        S_ON     = 6'h04,
        S_ARMED  = 6'h08,
        S_DETACH = 6'h10,
        S_DOWN   = 6'h20
    } dev_state_t;

    dev_state_t       state, next_state;     // Sequencer state
    logic [CNT_W-1:0] cnt, next_cnt;         // Shared timer
    logic [CNT_W-1:0] hold, next_hold;       // Key-low duration
    logic             reset_n_q, next_reset_n_q;  // Previous reset level
    logic             next_pstate, next_start, next_detach, next_powered;
    logic             pstate_q, start_q, detach_q, powered_q;

    // Next-state logic
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_reset_n_q = link.reset_n;
        // Key reads high unless pulled, thanks to the internal pull-up
        next_hold      = link.power_key_n ? '0 : ((&hold) ? hold : hold + 1'b1);
        next_pstate    = pstate_q;
        next_start     = start_q;
        next_detach    = 1'b0;
        next_powered   = powered_q;
        // Reboot acts on release of reset in any state but S_OFF
        if (link.reset_n && !reset_n_q && state != S_OFF) begin
            // No detach on unconditional reboot
            next_state   = S_BOOT;
            next_cnt     = '0;
            next_pstate  = 1'b0;
            next_start   = 1'b0;
            next_powered = 1'b1;
        end else if (!link.reset_n) begin
            // Held in reset: status and start outputs low, wait for release
            next_pstate = 1'b0;
            next_start  = 1'b0;
        end else begin
            unique case (state)
                S_OFF: begin
                    // Power rail comes up as the key is held
                    if (!link.power_key_n && hold >= CNT_W'(KEY_CYC - 1)) begin
                        next_state   = S_BOOT;
                        next_cnt     = '0;
                        next_powered = 1'b1;
                        next_start   = 1'b1;
                    end
                end
                S_BOOT: begin
                    next_start = 1'b1;
                    if (cnt >= CNT_W'(BOOT_TIME - 1)) begin
                        next_state  = S_ON;
                        next_pstate = 1'b1;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                S_ON: begin
                    // Key must first be released after power-on
                    if (sw_shutdown) begin
                        next_state  = S_DETACH;
                        next_cnt    = '0;
                        next_detach = 1'b1;
                    end else if (!link.power_key_n && hold >= CNT_W'(KEY_CYC - 1)
                                 && hold < CNT_W'(KEY_CYC)) begin
                        next_state = S_ARMED;
                    end
                end
                S_ARMED: begin
                    // Wait for key release before shutting down
                    if (link.power_key_n) begin
                        next_state  = S_DETACH;
                        next_cnt    = '0;
                        next_detach = 1'b1;
                    end
                end
                S_DETACH: begin
                    if (cnt >= CNT_W'(DETACH_T - 1)) begin
                        next_state = S_DOWN;
                        next_cnt   = '0;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
                S_DOWN: begin
                    if (cnt >= CNT_W'(OFF_T - 1)) begin
                        next_state   = S_OFF;
                        next_pstate  = 1'b0;
                        next_start   = 1'b0;
                        next_powered = 1'b0;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state     <= S_OFF;
            cnt       <= '0;
            hold      <= '0;
            reset_n_q <= 1'b1;
            pstate_q  <= 1'b0;
            start_q   <= 1'b0;
            detach_q  <= 1'b0;
            powered_q <= 1'b0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            hold      <= next_hold;
            reset_n_q <= next_reset_n_q;
            pstate_q  <= next_pstate;
            start_q   <= next_start;
            detach_q  <= next_detach;
            powered_q <= next_powered;
        end
    end

    // Outputs straight from flops
    assign link.power_state_out = pstate_q;
    assign link.start_out       = start_q;
    assign detach_req           = detach_q;
    assign powered              = powered_q;
endmodule : pwr_module_end

// [pwr_host_end.sv]
// Host-side controller pulsing the open-collector power key and reset lines.
`timescale 1ns/1ps
module pwr_host_end
    import pwr_key_pkg::*;
#(
    parameter int KEY_CYC   = KEY_MIN_CYC,
    parameter int HOLD_CYC  = START_HOLD_CYC,
    parameter int RST_CYC   = RESET_MIN_CYC
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Link
    pwr_key_if.host   link,
    // User side
    input  wire logic toggle_req,     // Request a power key pulse
    input  wire logic reboot_req,     // Emergency reboot request
    output logic      busy,           // Pulse in progress
    output logic      module_on       // Mirror of power status
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_KEY  = 4'h2,
        H_WAIT = 4'h4,
        H_RST  = 4'h8
    } host_state_t;

    host_state_t      state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic             key_oe_n, next_key_oe_n, rst_oe_n, next_rst_oe_n;
    logic             busy_q, next_busy, on_q, next_on;

    // Next-state logic; only pull-downs, never a high drive
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_key_oe_n = key_oe_n;
        next_rst_oe_n = rst_oe_n;
        next_busy     = busy_q;
        // Status mirror only follows the line while idle
        next_on       = (state == H_IDLE) ? link.power_state_out : on_q;
        unique case (state)
            H_IDLE: begin
                // Reboot is the caller's emergency exit only
                if (reboot_req) begin
                    next_state    = H_RST;
                    next_cnt      = '0;
                    next_rst_oe_n = 1'b0;
                    next_busy     = 1'b1;
                end else if (toggle_req) begin
                    next_state    = H_KEY;
                    next_cnt      = '0;
                    next_key_oe_n = 1'b0;
                    next_busy     = 1'b1;
                end
            end
            H_KEY: begin
                // Count rounded-up minimum, then also wait status plus 900 ms when powering on
                next_cnt = cnt + 1'b1;
                if (cnt >= CNT_W'(KEY_CYC - 1)) begin
                    if (link.power_state_out && !on_q) begin
                        next_state = H_WAIT;
                        next_cnt   = '0;
                    end else if (on_q || (!link.start_out && cnt >= CNT_W'(KEY_CYC))) begin
                        // Start output is registered, so give it one edge to show before giving up
                        next_state    = H_IDLE;
                        next_key_oe_n = 1'b1;
                        next_busy     = 1'b0;
                    end
                end
            end
            H_WAIT: begin
                next_cnt = cnt + 1'b1;
                if (cnt >= CNT_W'(HOLD_CYC - 1)) begin
                    next_state    = H_IDLE;
                    next_key_oe_n = 1'b1;
                    next_busy     = 1'b0;
                end
            end
            H_RST: begin
                next_cnt = cnt + 1'b1;
                if (cnt >= CNT_W'(RST_CYC - 1)) begin
                    next_state    = H_IDLE;
                    next_rst_oe_n = 1'b1;
                    next_busy     = 1'b0;
                end
            end
            default: begin
                next_state = H_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state    <= H_IDLE;
            cnt      <= '0;
            key_oe_n <= 1'b1;
            rst_oe_n <= 1'b1;
            busy_q   <= 1'b0;
            on_q     <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            key_oe_n <= next_key_oe_n;
            rst_oe_n <= next_rst_oe_n;
            busy_q   <= next_busy;
            on_q     <= next_on;
        end
    end

    assign link.power_key_oe_n = key_oe_n;
    assign link.reset_oe_n     = rst_oe_n;
    assign busy                = busy_q;
    assign module_on           = on_q;
endmodule : pwr_host_end

// [pwr_key_checker_sva.sv]
// Concurrent checks on the open-collector lines between host end and module end.
`timescale 1ns/1ps
module pwr_key_checker #(
    parameter int KEY_CYC  = 20,
    parameter int RST_CYC  = 6,
    parameter int BOOT_MAX = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link lines
    input wire logic power_key_oe_n,
    input wire logic reset_oe_n,
    input wire logic power_key_n,
    input wire logic reset_n,
    input wire logic power_state_out,
    input wire logic start_out
);
    logic [7:0] key_run, next_key_run;          // Low edges of the current key pulse
    logic [7:0] rst_run, next_rst_run;          // Low edges of the current reset pulse
    logic       on_at_press, next_on_at_press;  // Module was on when the press began
    // Run lengths; wrap is harmless since pulses stay well under 256 cycles
    always_comb begin
        next_key_run     = power_key_oe_n ? 8'h00 : key_run + 8'h01;
        next_rst_run     = reset_oe_n ? 8'h00 : rst_run + 8'h01;
        next_on_at_press = (!power_key_oe_n && key_run == 8'h00) ? power_state_out : on_at_press;
    end
    // Helper registers
    always_ff @(posedge ref_clk) begin
        key_run     <= rst ? 8'h00 : next_key_run;
        rst_run     <= rst ? 8'h00 : next_rst_run;
        on_at_press <= rst ? 1'b0 : next_on_at_press;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_key_pulse_len: assert property ($rose(power_key_oe_n) |-> key_run >= KEY_CYC)
        else $error("power key pulse too short");
    a_reset_pulse_len: assert property ($rose(reset_oe_n) |-> rst_run >= RST_CYC)
        else $error("reset pulse too short");
    a_start_then_status: assert property ($rose(start_out) |-> ##[1:BOOT_MAX] power_state_out)
        else $error("status did not follow start");
    a_status_needs_start: assert property (power_state_out |-> start_out)
        else $error("status high without start");
    a_hold_after_status: assert property ($rose(power_state_out) && !power_key_n |-> !power_key_n [*8])
        else $error("key released too early after status");
    a_off_after_release: assert property ($rose(power_key_oe_n) && on_at_press
        |-> power_state_out [*4] ##[1:8] !power_state_out)
        else $error("shutdown did not follow key release");
    a_fall_needs_release: assert property ($fell(power_state_out) |-> $past(power_key_n))
        else $error("status fell while key held");
    a_reboot_quiet: assert property (!reset_n ##1 !reset_n |-> !power_state_out && !start_out)
        else $error("module stayed up during reboot");
endmodule : pwr_key_checker

// [testbench.sv]
// Self-checking bench: host end facing module end, plus a lone module end.
`timescale 1ns/1ps
module testbench;
    import pwr_key_pkg::*;
    localparam int KEY  = 20;  // Shortened key hold
    localparam int BOOT = 5;   // Shortened boot time
    localparam int HOLD = 8;   // Shortened hold after status
    localparam int RSTC = 6;   // Shortened reset pulse
    logic ref_clk, rst, toggle_req, reboot_req, sw_shutdown;  // Bench-driven inputs
    logic busy, module_on, detach_req, powered;               // Observed outputs
    int   n_fail, checks, n_detach;                           // Counters
    pwr_key_if link();
    pwr_key_if link2();  // Lone module end, lines driven by the bench
    pwr_module_end #(.KEY_CYC(KEY), .BOOT_TIME(BOOT), .DETACH_T(4), .OFF_T(3)) pwr_module_end_i (
        .ref_clk(ref_clk), .rst(rst), .link(link), .sw_shutdown(sw_shutdown),
        .detach_req(detach_req), .powered(powered));
    pwr_module_end #(.KEY_CYC(KEY), .BOOT_TIME(BOOT), .DETACH_T(4), .OFF_T(3)) pwr_module_end_i2 (
        .ref_clk(ref_clk), .rst(rst), .link(link2), .sw_shutdown(1'b0), .detach_req(), .powered());
    pwr_host_end #(.KEY_CYC(KEY), .HOLD_CYC(HOLD), .RST_CYC(RSTC)) pwr_host_end_i (
        .ref_clk(ref_clk), .rst(rst), .link(link), .toggle_req(toggle_req), .reboot_req(reboot_req),
        .busy(busy), .module_on(module_on));
    pwr_key_checker #(.KEY_CYC(KEY), .RST_CYC(RSTC), .BOOT_MAX(BOOT + 3)) pwr_key_checker_i (
        .ref_clk(ref_clk), .rst(rst), .power_key_oe_n(link.power_key_oe_n), .reset_oe_n(link.reset_oe_n),
        .power_key_n(link.power_key_n), .reset_n(link.reset_n), .power_state_out(link.power_state_out),
        .start_out(link.start_out));
    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Count detach pulses sent to the network
    always @(posedge ref_clk) begin
        if (detach_req === 1'b1) n_detach = n_detach + 1;
    end
    task check(input string name, input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", name, exp, seen);
        end
    endtask : check
    task finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task ticks(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : ticks
    // One-cycle request to the host end; reboot wins over toggle
    task request(input logic reboot);
        @(posedge ref_clk);
        toggle_req <= !reboot;
        reboot_req <= reboot;
        @(posedge ref_clk);
        toggle_req <= 1'b0;
        reboot_req <= 1'b0;
        #1;
    endtask : request
    function automatic logic pick(input int which);
        pick = (which == 0) ? busy : link.power_state_out;
    endfunction : pick
    // Bounded wait; a timeout counts as a mismatch and ends the run
    task wait_for(input int which, input logic val);
        int k;
        k = 0;
        while (pick(which) !== val && k < 400) begin
            ticks(1);
            k++;
        end
        if (k == 400) begin
            n_fail++;
            $display("mismatch wait%0d expected %b seen timeout", which, val);
            finish_test();
        end
    endtask : wait_for
    initial begin
        {rst, toggle_req, reboot_req, sw_shutdown} = 4'h8;
        {link2.power_key_oe_n, link2.reset_oe_n} = 2'h3;
        {n_fail, checks, n_detach} = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        ticks(1);
        check("key_released", link.power_key_oe_n, 1'b1);
        check("reset_released", link.reset_oe_n, 1'b1);
        check("status_off", link.power_state_out, 1'b0);
        // One edge short of the key hold, then exactly the hold
        for (int len = KEY - 1; len <= KEY; len++) begin
            @(posedge ref_clk);
            link2.power_key_oe_n <= 1'b0;
            repeat (len) @(posedge ref_clk);
            link2.power_key_oe_n <= 1'b1;
            ticks(3);
            check("lone_start", link2.start_out, len == KEY);
        end
        // Power on through the host end
        request(1'b0);
        check("busy", busy, 1'b1);
        wait_for(1, 1'b1);
        check("start", link.start_out, 1'b1);
        check("key_held", link.power_key_n, 1'b0);
        wait_for(0, 1'b0);
        ticks(12);
        check("stays_on", link.power_state_out, 1'b1);
        check("module_on", module_on, 1'b1);
        // Emergency reboot must not detach
        n_detach = 0;
        request(1'b1);
        ticks(2);
        check("reset_pulled", link.reset_n, 1'b0);
        check("reboot_status", link.power_state_out, 1'b0);
        wait_for(0, 1'b0);
        wait_for(1, 1'b1);
        check("reboot_detach", n_detach != 0, 1'b0);
        // Key shutdown, power on again, then software shutdown
        for (int sw = 0; sw < 2; sw++) begin
            n_detach = 0;
            if (sw == 0) begin
                request(1'b0);
                ticks(10);
                check("held_still_on", link.power_state_out, 1'b1);
            end else begin
                @(posedge ref_clk);
                sw_shutdown <= 1'b1;
                @(posedge ref_clk);
                sw_shutdown <= 1'b0;
            end
            wait_for(1, 1'b0);
            ticks(2);
            check("detach_once", n_detach == 1, 1'b1);
            check("start_off", link.start_out, 1'b0);
            check("powered_off", powered, 1'b0);
            wait_for(0, 1'b0);
            if (sw == 0) request(1'b0);
            wait_for(0, 1'b0);
        end
        finish_test();
    end
endmodule : testbench
